// [bench/hbp_stage_model.sv]
// hbp_stage_model: behavioural three half-bridge power stage
// assumes enables active high; status pins are shown at their pulled-up level
`timescale 1ns/10ps
module hbp_stage_model (
    // controller side
    input  wire logic [2:0] phaseDrive,
    input  wire logic [2:0] phaseEnable,
    input  wire logic       modeSel,
    // injected conditions
    input  wire logic [2:0] ocHit,
    input  wire logic       warm,
    input  wire logic       hot,
    input  wire logic       uv,
    // open-drain status, pull-up level when released
    output logic            faultN,
    output logic            warnN
);
    logic       latchF = 1'b0;
    logic       sawLow = 1'b0;
    logic [2:0] cbcF   = 3'b000;
    logic [2:0] prevEn = 3'b000;
    logic [2:0] prevDrv  = 3'b000;
    logic [2:0] bstLow   = 3'b000;
    logic [2:0] tripHold = 3'b000;
    realtime    loStart [3] = '{0.0, 0.0, 0.0};
    logic [2:0] hiZ;
    logic [2:0] hiOn;
    logic [2:0] loOn;
    ////////////////////////////////////////////////////////////////////////////
    always @(hot or ocHit) begin
        if (hot || (modeSel && |ocHit)) begin
            latchF = 1'b1;
            sawLow = 1'b0;
        end
        if (!modeSel) cbcF = cbcF | ocHit;
        if (!modeSel) tripHold = tripHold | ocHit;
    end
    // a short low slot leaves the bootstrap low, so the stage cuts the high side
    // a limit trip is held only until the drive rises again
    always @(phaseDrive) begin
        for (int i = 0; i < 3; i++) begin
            if (prevDrv[i] && !phaseDrive[i]) loStart[i] = $realtime;
            if (!prevDrv[i] && phaseDrive[i]) begin
                bstLow[i]   = ($realtime - loStart[i]) < 50.0;
                tripHold[i] = 1'b0;
            end
        end
        prevDrv = phaseDrive;
    end
    // latch clears only after every enable went low and came back
    always @(phaseEnable) begin
        cbcF = cbcF & ~(phaseEnable & ~prevEn);
        if (phaseEnable == 3'b000) sawLow = 1'b1;
        if (sawLow && phaseEnable == 3'b111) begin
            latchF = 1'b0;
            sawLow = 1'b0;
        end
        prevEn = phaseEnable;
    end
    ////////////////////////////////////////////////////////////////////////////
    assign hiZ    = ~phaseEnable | {3{latchF | uv}} | cbcF;
    assign hiOn   = phaseDrive & ~hiZ & ~bstLow & ~tripHold;
    assign loOn   = (~phaseDrive | tripHold) & ~hiZ;
    assign faultN = !(latchF || uv || |cbcF);
    assign warnN  = !warm;
endmodule

// [bench/tb_hbp_controller.sv]
// tb_hbp_controller: self-checking bench for the stage controller
// assumes the stage model stands in for the power stage
`timescale 1ns/10ps
module tb_hbp_controller;
    import hbp_pkg::*;
    localparam int RCYC = 20;
    localparam int P    = 40;
    typedef struct {logic e; logic [31:0] d; logic [31:0] m;} hbp_note_t;
    logic        sys_clk = 0;
    logic        nrst = 0;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, modeSel, faultN, warnN;
    logic        warm = 0, hot = 0, uv = 0;
    logic [2:0]  phaseDrive, phaseEnable, ocHit = '0;
    logic [15:0] lfsr = 16'h0016;
    int          mismatches = 0, total_checks = 0, n, ex;
    int          hi [3];
    int          duty [3];
    hbp_note_t   expQ [$];
    hbp_note_t   note;
    always #2 sys_clk = ~sys_clk;
    hbp_controller #(.RESTART_CYC(RCYC)) i_hbp_controller (.sys_clk(sys_clk), .nrst(nrst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .phaseDrive(phaseDrive),
        .phaseEnable(phaseEnable), .protectionModeSelect(modeSel), .faultN(faultN),
        .thermalWarningN(warnN));
    hbp_stage_model i_hbp_stage_model (.phaseDrive(phaseDrive), .phaseEnable(phaseEnable),
        .modeSel(modeSel), .ocHit(ocHit), .warm(warm), .hot(hot), .uv(uv),
        .faultN(faultN), .warnN(warnN));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] nextRand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; the note is compared by the monitor below
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic e);
        int k;
        expQ.push_back('{e, d, m});
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk) penable <= 1;
        k = 0;
        do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin mismatches++; results(); end
        else begin psel <= 0; penable <= 0; @(posedge sys_clk); end
    endtask
    task automatic waitFault(input logic v, output int k);
        k = 0;
        while (faultN !== v && k < 500) begin @(posedge sys_clk); k++; end
        if (k >= 500) begin mismatches++; results(); end
    endtask
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1) begin
            note = expQ.pop_front();
            if (pwrite) check(pslverr, note.e);
            else check({pslverr, prdata & note.m}, {note.e, note.d & note.m});
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge sys_clk);
        nrst <= 1;
        @(posedge sys_clk);
        apb(0, ADDR_CTRL, CTRL_RESET, '1, 0);
        apb(0, ADDR_PERIOD, 32'(PERIOD_RESET), 32'h0000_ffff, 0);
        apb(0, 12'h018, 32'h0000_0000, '1, 1);
        apb(1, 12'h018, 32'h0000_0000, '0, 1);
        $display("test registers done");
        // full duty must still leave the low side its minimum slot
        lfsr = nextRand(lfsr);
        duty = '{P, int'(lfsr) % P, 0};
        apb(1, ADDR_PERIOD, P, '0, 0);
        for (int i = 0; i < 3; i++) apb(1, ADDR_DUTY_A + 12'(4 * i), duty[i], '0, 0);
        apb(0, ADDR_DUTY_B, duty[1], 32'h0000_ffff, 0);
        apb(1, ADDR_CTRL, 32'h0000_0001, '0, 0);
        repeat (2 * P) @(posedge sys_clk);
        hi = '{0, 0, 0};
        repeat (P) begin
            @(posedge sys_clk);
            for (int i = 0; i < 3; i++) hi[i] += int'(phaseDrive[i] === 1'b1);
        end
        check(phaseEnable, 3'b111);
        for (int i = 0; i < 3; i++) begin
            ex = (duty[i] > P - MIN_LS_CYC) ? P - MIN_LS_CYC : duty[i];
            check(hi[i], ex);
        end
        check(i_hbp_stage_model.bstLow, 3'b000);
        apb(1, ADDR_CTRL, 32'h0000_0005, '0, 0);
        @(posedge sys_clk);
        check(phaseEnable, 3'b101);
        apb(1, ADDR_CTRL, 32'h0000_0001, '0, 0);
        $display("test pwm done");
        for (int k = 1; k < 4; k++) begin
            warm <= k[1]; uv <= k[0];
            repeat (4) @(posedge sys_clk);
            apb(0, ADDR_STATUS, 32'(3 - k), 32'h0000_0003, 0);
            warm <= 0; uv <= 0;
            repeat (8) @(posedge sys_clk);
            apb(0, ADDR_STATUS, 32'h0000_0003, 32'h0000_0003, 0);
            check(phaseEnable, 3'b111);
        end
        $display("test status done");
        apb(1, ADDR_CTRL, 32'h0000_0021, '0, 0);
        hot <= 1;
        @(posedge sys_clk) hot <= 0;
        waitFault(1, n);
        check(n >= RCYC, 1'b1);
        for (int m = 0; m < 2; m++) begin
            apb(1, ADDR_CTRL, m ? 32'h0000_0041 : 32'h0000_0001, '0, 0);
            @(posedge sys_clk);
            check(modeSel, m[0]);
            ocHit <= 3'b010;
            @(posedge sys_clk) ocHit <= 0;
            repeat (4) @(posedge sys_clk);
            apb(0, ADDR_STATUS, 32'h0000_0002, 32'h0000_0003, 0);
            apb(1, ADDR_CTRL, m ? 32'h0000_0051 : 32'h0000_0011, '0, 0);
            waitFault(1, n);
            check(n >= RCYC, 1'b1);
            apb(0, ADDR_CTRL, m ? 32'h0000_0041 : 32'h0000_0001, '1, 0);
        end
        $display("test shutdown done");
        results();
    end
endmodule

// [verilog/hbp_controller.sv]
// hbp_controller: pwm and recovery controller for a three half-bridge stage
// assumes the stage status pins are pulled up outside and arrive asynchronously
`timescale 1ns/10ps

module hbp_controller
    import hbp_pkg::*;
#(
    parameter int RESTART_CYC = RESTART_WAIT_CY
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // apb slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // power stage pins
    output logic      [2:0]  phaseDrive,
    output logic      [2:0]  phaseEnable,
    output logic             protectionModeSelect,
    input  wire logic        faultN,
    input  wire logic        thermalWarningN
);

    ////////////////////////////////////////////////////////////////////////
    logic [1:0]       faultSync_q;
    logic [1:0]       warnSync_q;
    logic [31:0]      ctrl_q;
    logic [CNT_W-1:0] period_q;
    logic [CNT_W-1:0] duty_q [3];
    logic [CNT_W-1:0] cnt_q;
    logic [31:0]      wait_q;
    logic [7:0]       pulseCnt_q;
    logic [3:0]       stickyEvt_q;
    hbp_state_t       state_q;
    logic             flagLow;
    logic             warnLow;
    logic             wrEn;
    logic             rdEn;
    logic             mapped;

    // status pins are pulled up, so an idle line reads as normal
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            faultSync_q <= 2'b11;
            warnSync_q  <= 2'b11;
        end else begin
            faultSync_q <= {faultSync_q[0], faultN};
            warnSync_q  <= {warnSync_q[0], thermalWarningN};
        end
    end
    assign flagLow = !faultSync_q[1];
    assign warnLow = !warnSync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    assign wrEn   = psel && penable && pwrite;
    assign rdEn   = psel && !penable && !pwrite;
    assign mapped = paddr <= ADDR_STATUS && paddr[1:0] == 2'b00;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q    <= CTRL_RESET;
            period_q  <= PERIOD_RESET;
            duty_q[0] <= '0;
            duty_q[1] <= '0;
            duty_q[2] <= '0;
        end else begin
            if (state_q == ST_PULSE && pulseCnt_q == 8'(EN_PULSE_CYC)) begin
                ctrl_q[CTRL_PULSE] <= 1'b0;
            end
            if (wrEn && mapped) begin
                case (paddr)
                    ADDR_CTRL:   ctrl_q   <= pwdata;
                    ADDR_PERIOD: period_q <= pwdata[CNT_W-1:0];
                    ADDR_DUTY_A: duty_q[0] <= pwdata[CNT_W-1:0];
                    ADDR_DUTY_B: duty_q[1] <= pwdata[CNT_W-1:0];
                    ADDR_DUTY_C: duty_q[2] <= pwdata[CNT_W-1:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // status read, sticky bits clear by writing one
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stickyEvt_q <= '0;
        end else begin
            // set wins over a clear in the same cycle
            stickyEvt_q <= (stickyEvt_q & ~((wrEn && paddr == ADDR_STATUS) ? pwdata[7:4] : 4'h0))
                         | {warnLow && flagLow, flagLow && !warnLow, warnLow, flagLow};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (rdEn) begin
                case (paddr)
                    ADDR_CTRL:   prdata <= ctrl_q;
                    ADDR_PERIOD: prdata <= {16'h0000, period_q};
                    ADDR_DUTY_A: prdata <= {16'h0000, duty_q[0]};
                    ADDR_DUTY_B: prdata <= {16'h0000, duty_q[1]};
                    ADDR_DUTY_C: prdata <= {16'h0000, duty_q[2]};
                    ADDR_STATUS: prdata <= {22'h00_0000, state_q, stickyEvt_q,
                                            {warnLow, flagLow}, ~{warnLow, flagLow}};
                    default:     prdata <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // recovery sequencer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q    <= ST_RUN;
            wait_q     <= '0;
            pulseCnt_q <= '0;
        end else begin
            case (state_q)
                ST_RUN: begin
                    // undervoltage clears by itself; overtemperature and overcurrent faults are latched
                    if (flagLow) begin
                        state_q <= ST_LOCK;
                    end
                end
                ST_LOCK: begin
                    wait_q <= '0;
                    if (!flagLow) begin
                        state_q <= ST_RUN;
                    end else if (ctrl_q[CTRL_AUTO] || ctrl_q[CTRL_PULSE]) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    wait_q <= wait_q + 32'h0000_0001;
                    // a fault that clears while waiting needs no restart pulse
                    if (!flagLow) begin
                        state_q <= ST_RUN;
                    end else if (wait_q >= 32'(RESTART_CYC)) begin
                        state_q    <= ST_PULSE;
                        pulseCnt_q <= '0;
                    end
                end
                ST_PULSE: begin
                    pulseCnt_q <= pulseCnt_q + 8'h01;
                    if (pulseCnt_q == 8'(EN_PULSE_CYC)) begin
                        state_q <= ST_RUN;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pwm generation
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= (cnt_q >= period_q - 16'h0001) ? '0 : cnt_q + 16'h0001;
        end
    end

    // drive toggles every period while the duty is nonzero and the period exceeds MIN_LS_CYC, which clears a phase's trip hold after a limit event
    // and gives the low side its minimum slot for the bootstrap
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            phaseDrive           <= '0;
            phaseEnable          <= '0;
            protectionModeSelect <= 1'b0;
        end else begin
            protectionModeSelect <= ctrl_q[CTRL_MODE];
            for (int i = 0; i < 3; i++) begin
                phaseDrive[i] <= cnt_q < hbp_clamp(duty_q[i], period_q);
                // per-phase enable; a pulse on all three clears latched faults
                phaseEnable[i] <= ctrl_q[CTRL_RUN] && !ctrl_q[CTRL_EN_LO + (i % 3)]
                                  && state_q != ST_PULSE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    pulse_all_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == ST_PULSE |=> phaseEnable == 3'b000)
        else $error("enables not all low during restart pulse");

    wait_first_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == ST_WAIT && $past(state_q) == ST_LOCK |-> wait_q == 32'h0000_0000)
        else $error("restart wait did not start from zero");

    low_slot_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        cnt_q >= period_q - 16'(MIN_LS_CYC) && period_q > 16'(MIN_LS_CYC) |=> !phaseDrive[0])
        else $error("low side slot missing");

    mode_pin_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $changed(ctrl_q[CTRL_MODE]) |=> protectionModeSelect == $past(ctrl_q[CTRL_MODE]))
        else $error("mode pin not following control");

    run_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !ctrl_q[CTRL_RUN] |=> phaseEnable == 3'b000)
        else $error("phase enabled while stopped");

    fault_lock_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == ST_RUN && flagLow |=> state_q == ST_LOCK)
        else $error("fault not seen");

    pulse_len_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $rose(state_q == ST_PULSE) |-> (state_q == ST_PULSE) [*8])
        else $error("restart pulse too short");

    recover_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == ST_LOCK && !flagLow |=> state_q == ST_RUN)
        else $error("no automatic recovery");

    wait_exit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == ST_WAIT && !flagLow |=> state_q == ST_RUN)
        else $error("cleared fault still waiting");

    wait_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == ST_WAIT && flagLow && wait_q < 32'(RESTART_CYC) |=> state_q == ST_WAIT)
        else $error("restart wait cut short");

    wait_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == ST_WAIT |=> wait_q == $past(wait_q) + 32'h0000_0001)
        else $error("restart wait not counting");

    pulse_enter_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == ST_WAIT && flagLow && wait_q >= 32'(RESTART_CYC) |=> state_q == ST_PULSE)
        else $error("restart pulse not started");

    pulse_end_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == ST_PULSE && pulseCnt_q == 8'(EN_PULSE_CYC) |=> state_q == ST_RUN)
        else $error("restart pulse did not end");

    pulse_clr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == ST_PULSE && pulseCnt_q == 8'(EN_PULSE_CYC) && !(wrEn && paddr == ADDR_CTRL)
        |=> !ctrl_q[CTRL_PULSE])
        else $error("restart request not cleared");

    lock_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_q == ST_LOCK && flagLow && !ctrl_q[CTRL_AUTO] && !ctrl_q[CTRL_PULSE]
        |=> state_q == ST_LOCK)
        else $error("restart without request");

    phase_float_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        ctrl_q[CTRL_EN_LO + 1] |=> !phaseEnable[1])
        else $error("forced float phase still enabled");

    phase_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        ctrl_q[CTRL_RUN] && !ctrl_q[CTRL_EN_LO] && state_q != ST_PULSE |=> phaseEnable[0])
        else $error("unforced phase not enabled");

    drive_rise_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        cnt_q == '0 && duty_q[0] != '0 && period_q > 16'(MIN_LS_CYC) |=> phaseDrive[0])
        else $error("drive not raised at period start");

    drive_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        duty_q[1] == '0 |=> !phaseDrive[1])
        else $error("drive high at zero duty");

    cnt_wrap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        cnt_q >= period_q - 16'h0001 |=> cnt_q == '0)
        else $error("period counter did not wrap");

    mode_high_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        ctrl_q[CTRL_MODE] |=> protectionModeSelect)
        else $error("latched mode pin low");

    sticky_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        flagLow |=> stickyEvt_q[0])
        else $error("fault event not recorded");

    sticky_both_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        warnLow && flagLow |=> stickyEvt_q[3])
        else $error("warning with fault not recorded");
endmodule

// [verilog/hbp_pkg.sv]
// hbp_pkg: constants for the half-bridge stage controller
// assumes a 250 MHz system clock and an APB3 register slave
package hbp_pkg;
    localparam int          CLK_MHZ         = 250;
    localparam int          CLK_NS          = 1000 / CLK_MHZ;
    // low-side minimum on time, ns, rounded up to whole cycles
    localparam int          MIN_LS_NS       = 50;
    localparam int          MIN_LS_CYC      = (MIN_LS_NS + CLK_NS - 1) / CLK_NS;
    // wait after a latched shutdown, ms
    localparam int          RESTART_WAIT_MS = 1000;
    localparam int          RESTART_WAIT_CY = RESTART_WAIT_MS * 1000 * CLK_MHZ;
    // reset low pulse on the enables lasts this many cycles plus one
    localparam int          EN_PULSE_CYC    = 16;
    // register map, byte addresses
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_PERIOD     = 12'h004;
    localparam logic [11:0] ADDR_DUTY_A     = 12'h008;
    localparam logic [11:0] ADDR_DUTY_B     = 12'h00c;
    localparam logic [11:0] ADDR_DUTY_C     = 12'h010;
    localparam logic [11:0] ADDR_STATUS     = 12'h014;
    // control fields
    localparam int          CTRL_RUN        = 0;
    localparam int          CTRL_EN_LO      = 1;
    localparam int          CTRL_PULSE      = 4;
    localparam int          CTRL_AUTO       = 5;
    localparam int          CTRL_MODE       = 6;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
    localparam logic [15:0] PERIOD_RESET    = 16'h00FA;
    localparam int          CNT_W           = 16;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_LOCK  = 2'b01,
        ST_WAIT  = 2'b10,
        ST_PULSE = 2'b11
    } hbp_state_t;

    // the duty compare is clamped so the low side gets its minimum slot whenever the period is at least MIN_LS_CYC
    function automatic logic [CNT_W-1:0] hbp_clamp(input logic [CNT_W-1:0] duty,
                                                  input logic [CNT_W-1:0] period);
        logic [CNT_W-1:0] lim;
        lim = period - CNT_W'(MIN_LS_CYC);
        hbp_clamp = (duty > lim) ? lim : duty;
    endfunction
endpackage
